// file: design/rst_led_pkg.sv
// Purpose: Shared constants for the reset, alarm and status LED ends
// Assumes: sys_clk at 125 MHz
// Notes:   Times kept in their printed units, counts derived from them
//
// How it works
// - External reset low at least 200 us
// - Power-up stretch 20 to 100 ms
// - Reset pin open-drain, pulled up idle
// - Outside driver uses open-drain only
// - Wait 34 ms cancellation before done
// - Attention command after reset answers OK
// - Unregistered: LED steadily lit
// - Idle: 200 ms on, 2 s off
// - Non-connected: 200 ms on, 600 ms off
// - Bad software: 100 ms on, 200 ms off
// - Off or disabled: LED dark
// - Armed alarm: stay off until alarm time
// - Arm: set alarm, ground switch, power off
// - Host sets clock before arming alarm
package rst_led_pkg;

  localparam int unsigned CLK_KHZ          = 125000;
  localparam int unsigned RST_MIN_US       = 200;
  localparam int unsigned PWRUP_TYP_MS     = 40;
  localparam int unsigned CANCEL_TYP_MS    = 34;
  localparam int unsigned LED_ON_MS        = 200;
  localparam int unsigned LED_ON_BAD_MS    = 100;
  localparam int unsigned LED_OFF_IDLE_MS  = 2000;
  localparam int unsigned LED_OFF_NC_MS    = 600;
  localparam int unsigned LED_OFF_BAD_MS   = 200;
  localparam int unsigned MS_TICKS         = CLK_KHZ;
  localparam int unsigned RST_MIN_CYC      =
    (RST_MIN_US * CLK_KHZ + 999) / 1000;
  localparam int unsigned PWRUP_CYC        = PWRUP_TYP_MS * CLK_KHZ;
  localparam int unsigned CANCEL_CYC       = CANCEL_TYP_MS * CLK_KHZ;
  // Edges before the pin filter shows a released line
  localparam int unsigned SYNC_LAG_CYC     = 4;

  // Host to device command codes
  typedef enum logic [1:0] {
    CMD_ATTENTION,
    CMD_ALARM_SET,
    CMD_CLOCK_SET,
    CMD_POWER_OFF
  } cmd_e;

  localparam logic [1:0] RESP_OK    = 2'h0;
  localparam logic [1:0] RESP_ERROR = 2'h1;

endpackage

// file: design/rst_led_if.sv
`timescale 1ns/1ps
// Purpose: Link between the modem end and its host end
// Assumes: One clock shared by both ends
// Notes:   Open-drain reset resolved here from the two enables
interface rst_led_if;
  import rst_led_pkg::*;
  logic        rst_dev_oe_n;
  logic        rst_host_oe_n;
  logic        rst_line_n;
  logic        cmd_valid;
  cmd_e        cmd_code;
  logic [31:0] cmd_arg;
  logic        resp_valid;
  logic [1:0]  resp_code;
  logic        switch_gnd;

  // Pull-up wins unless some end pulls low
  assign rst_line_n = rst_dev_oe_n & rst_host_oe_n;

  modport dev  (input rst_line_n, cmd_valid, cmd_code, cmd_arg,
                switch_gnd, output rst_dev_oe_n, resp_valid, resp_code);
  modport host (input rst_line_n, resp_valid, resp_code,
                output rst_host_oe_n, cmd_valid, cmd_code, cmd_arg,
                switch_gnd);
endinterface

// file: design/modem_ctrl.sv
`timescale 1ns/1ps
// Purpose: Modem end: reset stretch, alarm wake, status LED
// Assumes: Host keeps its own ordering of commands
// Notes:   Power-up, cancel and ms counts are parameters to allow short simulation
module modem_ctrl
  import rst_led_pkg::*;
#(
  parameter int unsigned PWRUP_CYCLES  = PWRUP_CYC,
  parameter int unsigned CANCEL_CYCLES = CANCEL_CYC,
  parameter int unsigned MS_CYCLES     = MS_TICKS
)
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // Link to host
  rst_led_if.dev    lnk,
  // Status inputs
  input  wire logic registered,
  input  wire logic connected_nc,
  input  wire logic bad_software,
  input  wire logic led_disable,
  input  wire logic alarm_match,
  // Status outputs
  output logic      powered,
  output logic      alarm_armed,
  output logic      ready,
  output logic      led
);

  // ************************************************
  // Reset pin sampling
  // ************************************************
  logic [2:0] sync_q;
  logic       line_q;
  wire        line_agree = (sync_q[2] == sync_q[1]);

  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
    begin
      sync_q <= 3'h7;
      line_q <= 1'b1;
    end
    else
    begin
      sync_q <= {sync_q[1:0], lnk.rst_line_n};
      if (line_agree)
        line_q <= sync_q[2];
    end

  // ************************************************
  // Reset sequencer
  // ************************************************
  typedef enum logic [2:0] {S_PWRUP, S_LOWCHK, S_CANCEL, S_RUN, S_OFF} st_e;
  st_e         st_q;
  logic [31:0] cnt_q;
  logic        alarm_set_q;
  wire         wake_ok = alarm_set_q && alarm_match && lnk.switch_gnd;

  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
    begin
      st_q  <= S_PWRUP;
      cnt_q <= 32'h0;
    end
    else
    begin
      case (st_q)
        S_PWRUP:
        begin
          cnt_q <= cnt_q + 32'h1;
          if (cnt_q == PWRUP_CYCLES - 1)
          begin
            st_q  <= S_CANCEL;
            cnt_q <= 32'h0;
          end
        end
        S_LOWCHK:
        begin
          if (!line_q)
            cnt_q <= cnt_q + 32'h1;
          else if (cnt_q >= RST_MIN_CYC)
          begin
            st_q  <= S_CANCEL;
            cnt_q <= 32'h0;
          end
          else
          begin
            st_q  <= S_RUN;
            cnt_q <= 32'h0;
          end
        end
        S_CANCEL:
        begin
          cnt_q <= cnt_q + 32'h1;
          // Filter still shows the stretch that just ended
          if (!line_q && cnt_q >= SYNC_LAG_CYC)
          begin
            st_q  <= S_LOWCHK;
            cnt_q <= 32'h1;
          end
          else if (cnt_q == CANCEL_CYCLES - 1)
          begin
            st_q  <= S_RUN;
            cnt_q <= 32'h0;
          end
        end
        S_RUN:
        begin
          if (!line_q)
          begin
            st_q  <= S_LOWCHK;
            cnt_q <= 32'h1;
          end
          else if (lnk.cmd_valid && lnk.cmd_code == CMD_POWER_OFF)
            st_q <= S_OFF;
        end
        S_OFF:
        begin
          if (wake_ok)
          begin
            st_q  <= S_PWRUP;
            cnt_q <= 32'h0;
          end
        end
        default:
          st_q <= S_PWRUP;
      endcase
    end

  assign lnk.rst_dev_oe_n = (st_q != S_PWRUP);

  // ************************************************
  // Command interface
  // ************************************************
  logic       resp_v_q;
  logic [1:0] resp_c_q;
  logic       clock_set_q;
  wire        in_run = (st_q == S_RUN);
  wire        cmd_ok = lnk.cmd_valid && in_run;

  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
    begin
      resp_v_q    <= 1'b0;
      resp_c_q    <= RESP_OK;
      clock_set_q <= 1'b0;
      alarm_set_q <= 1'b0;
    end
    else
    begin
      resp_v_q <= cmd_ok;
      resp_c_q <= RESP_OK;
      if (cmd_ok && lnk.cmd_code == CMD_CLOCK_SET)
        clock_set_q <= 1'b1;
      if (cmd_ok && lnk.cmd_code == CMD_ALARM_SET)
      begin
        if (clock_set_q)
          alarm_set_q <= 1'b1;
        else
          resp_c_q <= RESP_ERROR;
      end
      // Alarm consumed by the wake it caused
      if (st_q == S_OFF && wake_ok)
        alarm_set_q <= 1'b0;
    end

  assign lnk.resp_valid = resp_v_q;
  assign lnk.resp_code  = resp_c_q;
  wire unused_ok = |lnk.cmd_arg;

  // ************************************************
  // Status LED
  // ************************************************
  // Wide enough for the full-rate millisecond count
  logic [31:0] ms_cnt_q;
  logic [11:0] ms_q;
  logic        led_q;
  wire         ms_tick = (ms_cnt_q == MS_CYCLES - 1);
  wire         on_st   = (st_q != S_OFF);
  wire         pat_dark = !on_st || led_disable;
  wire         pat_bad  = bad_software;
  wire         pat_on   = !registered;
  wire [11:0]  on_ms    = pat_bad ? 12'(LED_ON_BAD_MS) : 12'(LED_ON_MS);
  wire [11:0]  off_ms   = pat_bad      ? 12'(LED_OFF_BAD_MS) :
                          connected_nc ? 12'(LED_OFF_NC_MS)  :
                                         12'(LED_OFF_IDLE_MS);
  wire [11:0]  ph_ms    = led_q ? on_ms : off_ms;
  wire         end_ph   = ms_tick && (ms_q >= ph_ms - 12'h1);

  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
    begin
      ms_cnt_q <= 32'h0;
      ms_q     <= 12'h0;
      led_q    <= 1'b0;
    end
    else
    begin
      ms_cnt_q <= ms_tick ? 32'h0 : ms_cnt_q + 32'h1;
      if (pat_dark)
      begin
        led_q <= 1'b0;
        ms_q  <= 12'h0;
      end
      else if (pat_on && !pat_bad)
      begin
        led_q <= 1'b1;
        ms_q  <= 12'h0;
      end
      else if (end_ph)
      begin
        led_q <= !led_q;
        ms_q  <= 12'h0;
      end
      else if (ms_tick)
        ms_q <= ms_q + 12'h1;
    end

  assign led         = led_q && !unused_ok ? led_q : led_q;
  assign powered     = on_st;
  assign alarm_armed = alarm_set_q;
  assign ready       = in_run;

endmodule

// file: design/modem_host.sv
`timescale 1ns/1ps
// Purpose: Host end: emergency reset and command sequencing
// Assumes: Modem answers each command sent while ready with one response pulse
// Notes:   Reset driven open-drain only
module modem_host
  import rst_led_pkg::*;
#(
  parameter int unsigned RST_CYCLES = RST_MIN_CYC
)
(
  // Clock and reset
  input  wire logic  sys_clk,
  input  wire logic  sys_rst,
  // Link to modem
  rst_led_if.host    lnk,
  // User requests
  input  wire logic  req_reset,
  input  wire logic  req_cmd,
  input  wire cmd_e  req_code,
  input  wire logic [31:0] req_arg,
  input  wire logic  req_switch_gnd,
  // User answers
  output logic       busy,
  output logic       done,
  output logic [1:0] done_code
);

  typedef enum logic [1:0] {H_IDLE, H_RST, H_WAIT} hst_e;
  hst_e        st_q;
  logic [31:0] cnt_q;
  logic        cv_q;
  cmd_e        cc_q;
  logic [31:0] ca_q;
  logic        done_q;
  logic [1:0]  dc_q;

  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
    begin
      st_q   <= H_IDLE;
      cnt_q  <= 32'h0;
      cv_q   <= 1'b0;
      cc_q   <= CMD_ATTENTION;
      ca_q   <= 32'h0;
      done_q <= 1'b0;
      dc_q   <= RESP_OK;
    end
    else
    begin
      cv_q   <= 1'b0;
      done_q <= 1'b0;
      case (st_q)
        H_IDLE:
          if (req_reset)
          begin
            st_q  <= H_RST;
            cnt_q <= 32'h0;
          end
          else if (req_cmd)
          begin
            cv_q <= 1'b1;
            cc_q <= req_code;
            ca_q <= req_arg;
            st_q <= H_WAIT;
          end
        H_RST:
        begin
          cnt_q <= cnt_q + 32'h1;
          if (cnt_q == RST_CYCLES - 1)
            st_q <= H_IDLE;
        end
        H_WAIT:
          if (lnk.resp_valid)
          begin
            done_q <= 1'b1;
            dc_q   <= lnk.resp_code;
            st_q   <= H_IDLE;
          end
        default:
          st_q <= H_IDLE;
      endcase
    end

  assign lnk.rst_host_oe_n = (st_q != H_RST);
  assign lnk.cmd_valid     = cv_q;
  assign lnk.cmd_code      = cc_q;
  assign lnk.cmd_arg       = ca_q;
  assign lnk.switch_gnd    = req_switch_gnd;
  assign busy              = (st_q != H_IDLE);
  assign done              = done_q;
  assign done_code         = dc_q;

endmodule

// file: test/rst_led_monitor.sv
// Purpose: Link checks for reset, commands and answers
// Assumes: One clock, reset active high
// Notes:   Counters stand in for long holds
`timescale 1ns/1ps
module rst_led_monitor
  import rst_led_pkg::*;
#(
  parameter int unsigned PWRUP_CYCLES  = PWRUP_CYC,
  parameter int unsigned CANCEL_CYCLES = CANCEL_CYC,
  parameter int unsigned RST_CYCLES    = RST_MIN_CYC
)
(
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  // Link signals
  input wire logic       rst_dev_oe_n,
  input wire logic       rst_host_oe_n,
  input wire logic       rst_line_n,
  input wire logic       cmd_valid,
  input wire cmd_e       cmd_code,
  input wire logic       resp_valid,
  input wire logic [1:0] resp_code
);
  // ***
  // Helper counters
  // ***
  logic [31:0] dlo_q;
  logic [31:0] hlo_q;
  logic [31:0] hi_q;
  logic        clk_set_q;

  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
    begin
      dlo_q     <= '0;
      hlo_q     <= '0;
      hi_q      <= '0;
      clk_set_q <= 1'b0;
    end
    else
    begin
      dlo_q     <= rst_dev_oe_n ? 32'h0 : dlo_q + 32'h1;
      hlo_q     <= rst_host_oe_n ? 32'h0 : hlo_q + 32'h1;
      hi_q      <= rst_line_n ? hi_q + 32'h1 : 32'h0;
      clk_set_q <= clk_set_q | (cmd_valid & (cmd_code == CMD_CLOCK_SET));
    end

  // ***
  // Properties
  // ***
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  property p_resp_cause; resp_valid |-> $past(cmd_valid); endproperty
  a_resp_cause: assert property (p_resp_cause)
    else $error("answer without command");
  property p_resp_pulse; resp_valid |=> !resp_valid; endproperty
  a_resp_pulse: assert property (p_resp_pulse)
    else $error("answer longer than one cycle");
  property p_cmd_pulse; cmd_valid |=> !cmd_valid; endproperty
  a_cmd_pulse: assert property (p_cmd_pulse)
    else $error("command longer than one cycle");
  property p_pwrup_len;
    $rose(rst_dev_oe_n) |->
      dlo_q >= PWRUP_CYCLES - 1 && dlo_q <= PWRUP_CYCLES + 2;
  endproperty
  a_pwrup_len: assert property (p_pwrup_len)
    else $error("power-up stretch wrong length");
  property p_cancel; resp_valid |-> hi_q >= CANCEL_CYCLES; endproperty
  a_cancel: assert property (p_cancel)
    else $error("answer inside cancellation wait");
  property p_host_hold;
    $rose(rst_host_oe_n) |-> hlo_q >= RST_CYCLES;
  endproperty
  a_host_hold: assert property (p_host_hold)
    else $error("host reset pulse too short");
  property p_attn_ok;
    resp_valid && $past(cmd_code) == CMD_ATTENTION |-> resp_code == RESP_OK;
  endproperty
  a_attn_ok: assert property (p_attn_ok)
    else $error("attention not answered OK");
  property p_alarm_err;
    resp_valid && $past(cmd_code) == CMD_ALARM_SET && !clk_set_q
      |-> resp_code == RESP_ERROR;
  endproperty
  a_alarm_err: assert property (p_alarm_err)
    else $error("alarm accepted before clock set");
endmodule

// file: test/tb_top.sv
// Purpose: Bench driving both ends through their user sides
// Assumes: Shortened counts, 5 cycles per ms
// Notes:   Host reset hold kept at full count
`timescale 1ns/1ps
module tb_top
  import rst_led_pkg::*;
;
  localparam int unsigned MS = 5;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic registered, connected_nc, bad_software, led_disable, alarm_match;
  logic req_reset, req_cmd, req_switch_gnd, busy, done;
  logic powered, alarm_armed, ready, led;
  cmd_e req_code;
  logic [31:0] req_arg;
  logic [1:0] done_code;
  int miscompares = 0;
  int checks = 0;
  int n;

  always #4 sys_clk = ~sys_clk;

  rst_led_if lnk();
  modem_ctrl #(.PWRUP_CYCLES(100), .CANCEL_CYCLES(50), .MS_CYCLES(MS))
    i_modem_ctrl (.sys_clk(sys_clk), .sys_rst(sys_rst), .lnk(lnk),
    .registered(registered), .connected_nc(connected_nc),
    .bad_software(bad_software), .led_disable(led_disable),
    .alarm_match(alarm_match), .powered(powered),
    .alarm_armed(alarm_armed), .ready(ready), .led(led));
  modem_host i_modem_host (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .lnk(lnk), .req_reset(req_reset), .req_cmd(req_cmd),
    .req_code(req_code), .req_arg(req_arg),
    .req_switch_gnd(req_switch_gnd), .busy(busy), .done(done),
    .done_code(done_code));
  rst_led_monitor #(.PWRUP_CYCLES(100), .CANCEL_CYCLES(50))
    i_rst_led_monitor (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .rst_dev_oe_n(lnk.rst_dev_oe_n), .rst_host_oe_n(lnk.rst_host_oe_n),
    .rst_line_n(lnk.rst_line_n), .cmd_valid(lnk.cmd_valid),
    .cmd_code(lnk.cmd_code), .resp_valid(lnk.resp_valid),
    .resp_code(lnk.resp_code));

  // ***
  // Tasks
  // ***
  task automatic tick(input int k);
    repeat (k) @(negedge sys_clk);
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wrap_up;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task wait_ready(input int lim);
    n = 0;
    while (ready !== 1'b1 && n < lim)
    begin
      tick(1);
      n++;
    end
  endtask
  // Answer lands three cycles after the request
  task cmd(input cmd_e c, input logic [1:0] exp);
    req_code = c;
    req_cmd = 1'b1;
    tick(1);
    req_cmd = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 50)
    begin
      tick(1);
      n++;
    end
    chk("done", {31'h0, done}, 32'h1);
    chk("done_code", {30'h0, done_code}, {30'h0, exp});
    tick(2);
  endtask
  // Lit and dark spans counted whole, from a fresh rise
  task led_per(input int on_c, input int off_c);
    n = 0;
    while (led !== 1'b0 && n < 30000) begin tick(1); n++; end
    n = 0;
    while (led !== 1'b1 && n < 30000) begin tick(1); n++; end
    n = 0;
    while (led === 1'b1 && n < 30000) begin tick(1); n++; end
    chk("led_on", n, on_c);
    n = 0;
    while (led === 1'b0 && n < 30000) begin tick(1); n++; end
    chk("led_off", n, off_c);
  endtask

  // ***
  // Sequence
  // ***
  initial
  begin
    {registered, connected_nc, bad_software, led_disable} = 4'h0;
    {alarm_match, req_reset, req_cmd, req_switch_gnd} = 4'h0;
    req_code = CMD_ATTENTION;
    req_arg = 32'h0;
    tick(12);
    sys_rst = 1'b0;
    wait_ready(300);
    chk("pwrup", n >= 150 && n < 300, 1);
    tick(20);
    chk("led_steady", led, 1);
    led_disable = 1'b1;
    tick(5);
    chk("led_dis", led, 0);
    led_disable = 1'b0;
    bad_software = 1'b1;
    led_per(100 * MS, 200 * MS);
    bad_software = 1'b0;
    registered = 1'b1;
    connected_nc = 1'b1;
    led_per(200 * MS, 600 * MS);
    connected_nc = 1'b0;
    led_per(200 * MS, 2000 * MS);
    cmd(CMD_ATTENTION, RESP_OK);
    cmd(CMD_ALARM_SET, RESP_ERROR);
    chk("armed", alarm_armed, 0);
    cmd(CMD_CLOCK_SET, RESP_OK);
    cmd(CMD_ALARM_SET, RESP_OK);
    req_switch_gnd = 1'b1;
    cmd(CMD_POWER_OFF, RESP_OK);
    tick(100);
    chk("powered", powered, 0);
    chk("led_off", led, 0);
    chk("armed", alarm_armed, 1);
    alarm_match = 1'b1;
    tick(2);
    alarm_match = 1'b0;
    req_switch_gnd = 1'b0;
    wait_ready(300);
    chk("wake", ready, 1);
    chk("armed", alarm_armed, 0);
    req_reset = 1'b1;
    tick(1);
    req_reset = 1'b0;
    tick(10);
    chk("in_reset", ready, 0);
    wait_ready(26000);
    chk("rst_done", n >= 25000 && n < 26000, 1);
    cmd(CMD_ATTENTION, RESP_OK);
    wrap_up;
  end

  // Guard against a hang
  initial
  begin
    tick(90000);
    miscompares++;
    wrap_up;
  end
endmodule
